// ---- dac_device_model.sv ----
/*
 * behavioural model of one two-byte loaded 12-bit dac load port.
 * assumes active-low selects and load strobe straight from the host pins.
 */
`timescale 1ns/1ps
`default_nettype none
module dac_device_model (
    input  wire logic        low_byte_select_n,
    input  wire logic        high_byte_select_n,
    input  wire logic        load_output_strobe_n,
    input  wire logic        format_or_override_n,
    input  wire logic        override_level,
    input  wire logic [7:0]  dac_data,
    output logic      [11:0] dac_value
);
    // ----------------------------------------------------------------
    // input and dac registers
    // ----------------------------------------------------------------
    logic [7:0]  low_q  = 8'h00;
    logic [3:0]  high_q = 4'h0;
    logic [11:0] dac_q  = 12'h000;

    // transparent latches as on the part: no clock inside the device
    always @* begin
        if (!low_byte_select_n) low_q = dac_data;
        if (!high_byte_select_n) high_q = dac_data[3:0];
        if (!load_output_strobe_n) dac_q = {high_q, low_q};
    end

    assign dac_value = !format_or_override_n ? {12{override_level}} : dac_q;
endmodule
`default_nettype wire

// ---- dac_load_host.sv ----
/*
 * host side write sequencer for a bank of two-byte loaded 12-bit dacs.
 * assumes the user logic on sys_clk issues requests only while ready is high,
 * and that each converter's byte selects and the shared load strobe are wired
 * straight from these ports.
 */
// What this block does
// - base address write asserts low-byte select, latching bus byte into low register.
// - high byte carries code bits 11..8 in its lower nibble; low byte the rest.
// - auto mode: load strobe pulses with second byte select, updating output that write.
// - high-first host: high select first, load strobe goes with low select.
// - high-first host sends high byte from lower address, then low byte.
// - low-first host: low select first, then high select together with load strobe.
// - each converter gets own selects; one shared load strobe updates all together.
// - strobed mode: two byte writes, then a separate third load strobe write.
`timescale 1ns/1ps
`default_nettype none

module dac_load_host #(
    parameter int NUM_DACS = 2,
    parameter int IDX_W    = 1
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic                 write_req,
    input  wire logic [1:0]           write_mode,
    input  wire logic [IDX_W-1:0]     write_dac,
    input  wire logic [11:0]          write_code,
    input  wire logic                 load_req,
    input  wire logic                 override_req,
    input  wire logic                 override_ones,
    output logic                      ready,
    output logic                      done,
    output logic [7:0]                dac_data,
    output logic [NUM_DACS-1:0]       low_byte_select_n,
    output logic [NUM_DACS-1:0]       high_byte_select_n,
    output logic                      load_output_strobe_n,
    output logic                      format_or_override_n,
    output logic                      override_level
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic low_goes_first(input logic [1:0] mode);
        return mode != dac_load_host_pkg::MODE_AUTO_HIGH_FIRST;
    endfunction

    function automatic logic [7:0] byte_of(input logic [11:0] code, input logic high);
        if (high) begin
            return {4'h0, code[dac_load_host_pkg::CODE_W-1:dac_load_host_pkg::HIGH_NIBBLE_LO]};
        end
        return code[dac_load_host_pkg::BYTE_W-1:0];
    endfunction

    localparam logic [3:0] SETUP_LD = 4'(dac_load_host_pkg::SETUP_CYC - 1);
    localparam logic [3:0] PULSE_LD = 4'(dac_load_host_pkg::PULSE_CYC - 1);
    localparam logic [3:0] HOLD_LD  = 4'(dac_load_host_pkg::HOLD_CYC - 1);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    dac_load_host_pkg::state_t state_q, state_d;
    logic [3:0]       cnt_q, cnt_d;
    logic [7:0]       data_q, data_d;
    logic [11:0]      code_q, code_d;
    logic [1:0]       mode_q, mode_d;
    logic [IDX_W-1:0] idx_q, idx_d;
    logic             lo_q, lo_d;
    logic             hi_q, hi_d;
    logic             ld_q, ld_d;
    logic             done_q, done_d;
    logic             ovr_q, ovr_d;
    logic             lvl_q, lvl_d;
    logic             first_low;

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        data_d    = data_q;
        code_d    = code_q;
        mode_d    = mode_q;
        idx_d     = idx_q;
        done_d    = 1'b0;
        first_low = low_goes_first(mode_q);
        ovr_d     = override_req;
        lvl_d     = override_ones;
        unique case (state_q)
            dac_load_host_pkg::ST_IDLE: begin
                if (write_req) begin
                    code_d  = write_code;
                    mode_d  = write_mode;
                    idx_d   = write_dac;
                    // high-first host sends the byte that sits at the lower address first
                    data_d  = byte_of(write_code, !low_goes_first(write_mode));
                    cnt_d   = SETUP_LD;
                    state_d = dac_load_host_pkg::ST_SET1;
                end else if (load_req) begin
                    cnt_d   = PULSE_LD;
                    state_d = dac_load_host_pkg::ST_LD_ACT;
                end
            end
            dac_load_host_pkg::ST_SET1: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h0) begin
                    cnt_d   = PULSE_LD;
                    state_d = dac_load_host_pkg::ST_ACT1;
                end
            end
            dac_load_host_pkg::ST_ACT1: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h0) begin
                    cnt_d   = HOLD_LD;
                    state_d = dac_load_host_pkg::ST_HOLD1;
                end
            end
            dac_load_host_pkg::ST_HOLD1: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h0) begin
                    data_d  = byte_of(code_q, first_low);
                    cnt_d   = SETUP_LD;
                    state_d = dac_load_host_pkg::ST_SET2;
                end
            end
            dac_load_host_pkg::ST_SET2: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h0) begin
                    cnt_d   = PULSE_LD;
                    state_d = dac_load_host_pkg::ST_ACT2;
                end
            end
            dac_load_host_pkg::ST_ACT2: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h0) begin
                    cnt_d   = HOLD_LD;
                    state_d = dac_load_host_pkg::ST_HOLD2;
                end
            end
            dac_load_host_pkg::ST_HOLD2,
            dac_load_host_pkg::ST_LD_HOLD: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h0) begin
                    done_d  = 1'b1;
                    state_d = dac_load_host_pkg::ST_IDLE;
                end
            end
            dac_load_host_pkg::ST_LD_ACT: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h0) begin
                    cnt_d   = HOLD_LD;
                    state_d = dac_load_host_pkg::ST_LD_HOLD;
                end
            end
        endcase
        // strobes follow the next state so they leave flops cleanly
        lo_d = ((state_d == dac_load_host_pkg::ST_ACT1) && first_low) ||
               ((state_d == dac_load_host_pkg::ST_ACT2) && !first_low);
        hi_d = ((state_d == dac_load_host_pkg::ST_ACT1) && !first_low) ||
               ((state_d == dac_load_host_pkg::ST_ACT2) && first_low);
        // auto modes fire the load with the second byte; strobed mode never does
        ld_d = ((state_d == dac_load_host_pkg::ST_ACT2) &&
                (mode_d != dac_load_host_pkg::MODE_STROBED)) ||
               (state_d == dac_load_host_pkg::ST_LD_ACT);
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= dac_load_host_pkg::ST_IDLE;
            cnt_q   <= 4'h0;
            data_q  <= dac_load_host_pkg::DATA_RESET;
            code_q  <= dac_load_host_pkg::CODE_RESET;
            mode_q  <= dac_load_host_pkg::MODE_AUTO_LOW_FIRST;
            idx_q   <= '0;
            lo_q    <= 1'b0;
            hi_q    <= 1'b0;
            ld_q    <= 1'b0;
            done_q  <= 1'b0;
            ovr_q   <= 1'b0;
            lvl_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            data_q  <= data_d;
            code_q  <= code_d;
            mode_q  <= mode_d;
            idx_q   <= idx_d;
            lo_q    <= lo_d;
            hi_q    <= hi_d;
            ld_q    <= ld_d;
            done_q  <= done_d;
            ovr_q   <= ovr_d;
            lvl_q   <= lvl_d;
        end
    end

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    // one select pair per converter; the load strobe is common to the bank
    for (genvar g = 0; g < NUM_DACS; g++) begin : g_sel
        assign low_byte_select_n[g]  = !(lo_q && (idx_q == IDX_W'(g)));
        assign high_byte_select_n[g] = !(hi_q && (idx_q == IDX_W'(g)));
    end

    assign load_output_strobe_n = !ld_q;
    assign dac_data             = data_q;
    // override acts inside the converter; the host only holds the two levels
    assign format_or_override_n = !ovr_q;
    assign override_level       = lvl_q;
    assign ready                = (state_q == dac_load_host_pkg::ST_IDLE);
    assign done                 = done_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_low_byte_data: assert property (lo_q |-> dac_data == code_q[7:0])
        else $error("low byte select without low code byte");
    a_high_byte_pad: assert property (hi_q |-> dac_data == {4'h0, code_q[11:8]})
        else $error("high byte not right justified");
    a_auto_load_pair: assert property ((!load_output_strobe_n && mode_q != dac_load_host_pkg::MODE_STROBED
        && state_q != dac_load_host_pkg::ST_LD_ACT) |-> (lo_q || hi_q))
        else $error("auto load strobe without a byte select");
    a_high_first_order: assert property (($rose(hi_q) && mode_q == dac_load_host_pkg::MODE_AUTO_HIGH_FIRST)
        |-> ##[1:20] (lo_q && ld_q))
        else $error("high first write not followed by low byte with load");
    a_low_first_order: assert property (($rose(lo_q) && mode_q == dac_load_host_pkg::MODE_AUTO_LOW_FIRST)
        |-> ##[1:20] (hi_q && ld_q))
        else $error("low first write not followed by high byte with load");
    a_one_select_only: assert property ($countones(~{low_byte_select_n, high_byte_select_n}) <= 1)
        else $error("more than one byte select active");
    a_strobe_load_alone: assert property ((ld_q && mode_q == dac_load_host_pkg::MODE_STROBED)
        |-> (!lo_q && !hi_q))
        else $error("strobed load overlaps a byte write");
    a_override_track: assert property ($stable(override_req) && $stable(override_ones)
        |=> (format_or_override_n == !$past(override_req) && override_level == $past(override_ones)))
        else $error("override pins do not follow request");
    a_no_early_load: assert property ((mode_q == dac_load_host_pkg::MODE_STROBED && (lo_q || hi_q))
        |-> load_output_strobe_n)
        else $error("load strobe during strobed byte write");

    c_auto_low_first: cover property ($rose(ld_q) && lo_q == 1'b0 && hi_q &&
        mode_q == dac_load_host_pkg::MODE_AUTO_LOW_FIRST);
    c_auto_high_first: cover property ($rose(ld_q) && lo_q && mode_q == dac_load_host_pkg::MODE_AUTO_HIGH_FIRST);
    c_strobed_load: cover property (state_q == dac_load_host_pkg::ST_LD_ACT ##[1:40] done);
    c_override_ones: cover property (!format_or_override_n && override_level);

endmodule

`default_nettype wire

// ---- dac_load_host_pkg.sv ----
/*
 * constants, mode codes and states for the two-byte dac load host.
 * assumes a 10 MHz sys_clk; all times are turned into cycle counts here.
 */
package dac_load_host_pkg;

    // ----------------------------------------------------------------
    // clock and write-cycle timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SETUP_NS       = 100;
    localparam int PULSE_NS       = 150;
    localparam int HOLD_NS        = 100;
    // least times round up, and none is below one cycle
    localparam int SETUP_CYC      = ((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                    ((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int PULSE_CYC      = ((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                    ((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int HOLD_CYC       = ((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                    ((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int CNT_W          = 4;

    // ----------------------------------------------------------------
    // data layout and transfer modes
    // ----------------------------------------------------------------
    localparam int CODE_W         = 12;
    localparam int BYTE_W         = 8;
    localparam int HIGH_NIBBLE_LO = 8;
    localparam logic [1:0] MODE_AUTO_LOW_FIRST  = 2'h0;
    localparam logic [1:0] MODE_AUTO_HIGH_FIRST = 2'h1;
    localparam logic [1:0] MODE_STROBED         = 2'h2;
    localparam logic [7:0] DATA_RESET           = 8'h00;
    localparam logic [11:0] CODE_RESET          = 12'h000;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SET1,
        ST_ACT1,
        ST_HOLD1,
        ST_SET2,
        ST_ACT2,
        ST_HOLD2,
        ST_LD_ACT,
        ST_LD_HOLD
    } state_t;

endpackage

// ---- test_dac_load_host.sv ----
/*
 * self-checking bench for the dac load host with two device models.
 * assumes 10 MHz sys_clk; inputs change on the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module test_dac_load_host;
    logic sys_clk = 1'b0, reset_n, write_req = 1'b0, load_req = 1'b0;
    logic override_req = 1'b0, override_ones = 1'b0, write_dac = 1'b0;
    logic [1:0]  write_mode = 2'h0;
    logic [11:0] write_code = 12'h000;
    logic ready, done, load_output_strobe_n, format_or_override_n, override_level;
    logic [7:0]  dac_data;
    logic [1:0]  low_byte_select_n, high_byte_select_n;
    logic [1:0][11:0] dac_value;
    int num_errors = 0;
    int n_tests = 0;

    always #50 sys_clk = ~sys_clk;

    dac_load_host #(.NUM_DACS(2), .IDX_W(1)) dac_load_host_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .write_req(write_req), .write_mode(write_mode), .write_dac(write_dac), .write_code(write_code),
        .load_req(load_req), .override_req(override_req), .override_ones(override_ones), .ready(ready),
        .done(done), .dac_data(dac_data), .low_byte_select_n(low_byte_select_n),
        .high_byte_select_n(high_byte_select_n), .load_output_strobe_n(load_output_strobe_n),
        .format_or_override_n(format_or_override_n), .override_level(override_level));

    // shared load strobe and data, one select pair per converter
    for (genvar g = 0; g < 2; g++) begin : dev
        dac_device_model dac_device_model_inst (.low_byte_select_n(low_byte_select_n[g]),
            .high_byte_select_n(high_byte_select_n[g]), .load_output_strobe_n(load_output_strobe_n),
            .format_or_override_n(format_or_override_n), .override_level(override_level),
            .dac_data(dac_data), .dac_value(dac_value[g]));
    end

    // ----------------------------------------------------------------
    // compare and closing
    // ----------------------------------------------------------------
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // one write, watching which pins fall in which cycle
    task automatic do_write(input logic [1:0] mode, input logic dac, input logic [11:0] code);
        int lo_at, hi_at, ld_at, i;
        logic [7:0] lo_b, hi_b;
        logic stray, fin;
        lo_at = -1; hi_at = -1; ld_at = -1; stray = 1'b0; fin = 1'b0; lo_b = 8'h00; hi_b = 8'h00;
        write_req = 1'b1; write_mode = mode; write_dac = dac; write_code = code;
        @(negedge sys_clk);
        write_req = 1'b0;
        for (i = 1; i < 30 && !fin; i++) begin
            if (!low_byte_select_n[dac] && lo_at < 0) begin lo_at = i; lo_b = dac_data; end
            if (!high_byte_select_n[dac] && hi_at < 0) begin hi_at = i; hi_b = dac_data; end
            if (!load_output_strobe_n && ld_at < 0) ld_at = i;
            if (!low_byte_select_n[!dac] || !high_byte_select_n[!dac]) stray = 1'b1;
            fin = done;
            @(negedge sys_clk);
        end
        chk({11'h0, fin}, 12'h001);
        chk({11'h0, stray}, 12'h000);
        chk({4'h0, lo_b}, {4'h0, code[7:0]});
        chk({4'h0, hi_b}, {8'h00, code[11:8]});
        chk({11'h0, lo_at > 0 && hi_at > 0}, 12'h001);
        if (mode == 2'h0) chk({10'h0, lo_at < hi_at, ld_at == hi_at}, 12'h003);
        if (mode == 2'h1) chk({10'h0, hi_at < lo_at, ld_at == lo_at}, 12'h003);
        if (mode == 2'h2) chk({11'h0, ld_at < 0}, 12'h001);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic auto_modes();
        do_write(2'h0, 1'b0, 12'hA5C);
        chk(dac_value[0], 12'hA5C);
        do_write(2'h1, 1'b1, 12'h3F1);
        chk(dac_value[1], 12'h3F1);
        chk(dac_value[0], 12'hA5C);
    endtask

    task automatic strobed_pair();
        int i;
        logic sel_seen, ld_seen, fin;
        do_write(2'h2, 1'b0, 12'h123);
        do_write(2'h2, 1'b1, 12'h8E7);
        chk(dac_value[0], 12'hA5C);
        chk(dac_value[1], 12'h3F1);
        sel_seen = 1'b0; ld_seen = 1'b0; fin = 1'b0;
        load_req = 1'b1;
        @(negedge sys_clk);
        load_req = 1'b0;
        for (i = 0; i < 20 && !fin; i++) begin
            if (!load_output_strobe_n) ld_seen = 1'b1;
            if (!load_output_strobe_n && (low_byte_select_n != 2'h3 || high_byte_select_n != 2'h3))
                sel_seen = 1'b1;
            fin = done;
            @(negedge sys_clk);
        end
        chk({10'h0, ld_seen, sel_seen}, 12'h002);
        chk(dac_value[0], 12'h123);
        chk(dac_value[1], 12'h8E7);
    endtask

    task automatic override_levels();
        override_req = 1'b1; override_ones = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({11'h0, format_or_override_n}, 12'h000);
        chk(dac_value[0], 12'hFFF);
        override_ones = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(dac_value[1], 12'h000);
        override_req = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(dac_value[1], 12'h8E7);
    endtask

    // reset in mid-write: pins fall back idle and the converter keeps its old code
    task automatic reset_abort();
        write_req = 1'b1; write_mode = 2'h0; write_dac = 1'b0; write_code = 12'h5A5;
        @(negedge sys_clk);
        write_req = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({11'h0, low_byte_select_n[0]}, 12'h000);
        reset_n = 1'b0;
        @(negedge sys_clk);
        chk({9'h0, ready, low_byte_select_n == 2'h3, load_output_strobe_n}, 12'h007);
        chk({4'h0, dac_data, high_byte_select_n, 2'h0}, 12'h00C);
        reset_n = 1'b1;
        @(negedge sys_clk);
        chk(dac_value[0], 12'h123);
        do_write(2'h0, 1'b0, 12'h5A5);
        chk(dac_value[0], 12'h5A5);
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        // reset falls at time zero so the sequencer leaves its unknown state at once
        reset_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk({9'h0, ready, low_byte_select_n == 2'h3, load_output_strobe_n}, 12'h007);
        reset_n = 1'b1;
        @(negedge sys_clk);
        auto_modes();
        strobed_pair();
        override_levels();
        reset_abort();
        end_sim();
    end

    // whole run is near 70 cycles; 3000 leaves ample margin
    initial begin
        repeat (3000) @(posedge sys_clk);
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
